// *** logic/flop_pkg.sv ***
// shared types and constants for the flip-flop primitive set
package flop_pkg;

  // ==========================================================
  // trigger edge choices
  typedef enum logic {rising_trigger, falling_trigger} trigger_edge_type;

  // ==========================================================
  // true and complementary output pair
  typedef struct packed {
    logic q;
    logic q_n;
  } flop_out_type;

  // ==========================================================
  // initial-condition defaults per primitive and one edge default shared by the three clocked primitives
  localparam logic SR_INIT = 1'h0;
  localparam logic CSR_INIT = 1'h0;
  localparam logic JK_INIT = 1'h0;
  localparam logic DATA_INIT = 1'h0;
  localparam trigger_edge_type DEFAULT_EDGE = rising_trigger;

endpackage

// *** logic/edge_trigger.sv ***
// edge detector on a primitive's clock input, sampled by the system clock
`timescale 1ns/10ps
module edge_trigger #(
  parameter flop_pkg::trigger_edge_type trigger_edge_select = flop_pkg::DEFAULT_EDGE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic trigger
);

  logic previous;
  logic next_previous;

  // ==========================================================
  // previous-level register
  always_comb
  begin
    next_previous = level;
  end

  // loads the present level every cycle, reset included, so a high clock at release is no edge
  always_ff @(posedge clk)
  begin
    previous <= next_previous;
  end

  // ==========================================================
  // edge decode
  always_comb
  begin
    if (trigger_edge_select == flop_pkg::rising_trigger)
    begin
      trigger = ~previous & level & ~rst;
    end
    else
    begin
      trigger = previous & ~level & ~rst;
    end
  end

endmodule

// *** logic/flip_flop_primitives.sv ***
// set-reset, clocked set-reset, clocked toggle-capable and clocked data flops
// Function
// - set-reset: set, reset in; true, complement out
// - complement output always inverse of true output
// - true output loads initial condition at start
// - set high, reset low drives output 1
// - reset high, set low drives output 0
// - both set and reset high holds outputs
// - clocked set-reset: set, reset, clock inputs
// - clocked set-reset triggers on selected edge
// - clocked outputs change only at selected edge or on system reset
// - clocked set-reset applies set-reset logic at edge
// - toggle-capable flop: set-side, reset-side, clock inputs
// - toggle-capable flop triggers on selected edge
// - toggle-capable acts as set-reset unless both high
// - both high at edge inverts each output
// - data flop has per-instance edge select
// - data flop: data, clock; output follows data
`timescale 1ns/10ps
module flip_flop_primitives #(
  parameter logic SR_INITIAL = flop_pkg::SR_INIT,
  parameter logic CSR_INITIAL = flop_pkg::CSR_INIT,
  parameter logic JK_INITIAL = flop_pkg::JK_INIT,
  parameter logic DATA_INITIAL = flop_pkg::DATA_INIT,
  parameter flop_pkg::trigger_edge_type CSR_EDGE = flop_pkg::DEFAULT_EDGE,
  parameter flop_pkg::trigger_edge_type JK_EDGE = flop_pkg::DEFAULT_EDGE,
  parameter flop_pkg::trigger_edge_type DATA_EDGE = flop_pkg::DEFAULT_EDGE
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic SR_SET,
  input wire logic SR_RESET,
  output flop_pkg::flop_out_type SR_OUT,
  input wire logic CSR_SET,
  input wire logic CSR_RESET,
  input wire logic CSR_CLOCK,
  output flop_pkg::flop_out_type CSR_OUT,
  input wire logic JK_SET,
  input wire logic JK_RESET,
  input wire logic JK_CLOCK,
  output flop_pkg::flop_out_type JK_OUT,
  input wire logic DATA_IN,
  input wire logic DATA_CLOCK,
  output flop_pkg::flop_out_type DATA_OUT
);

  // ==========================================================
  // set-reset resolution shared by three primitives
  // both-high holds rather than going undefined, easier to debug
  function automatic logic resolve(input logic set, input logic reset, input logic hold);
    logic result;
    result = hold;
    if (set & ~reset)
    begin
      result = 1'h1;
    end
    else if (reset & ~set)
    begin
      result = 1'h0;
    end
    return result;
  endfunction

  logic csr_trigger;
  logic jk_trigger;
  logic data_trigger;
  flop_pkg::flop_out_type next_sr;
  flop_pkg::flop_out_type next_csr;
  flop_pkg::flop_out_type next_jk;
  flop_pkg::flop_out_type next_data;

  // ==========================================================
  // edge detectors, one per clocked primitive
  edge_trigger #(.trigger_edge_select(CSR_EDGE)) csr_edge (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .level(CSR_CLOCK),
    .trigger(csr_trigger)
  );

  edge_trigger #(.trigger_edge_select(JK_EDGE)) jk_edge (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .level(JK_CLOCK),
    .trigger(jk_trigger)
  );

  edge_trigger #(.trigger_edge_select(DATA_EDGE)) data_edge (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .level(DATA_CLOCK),
    .trigger(data_trigger)
  );

  // ==========================================================
  // next state of all four primitives
  always_comb
  begin
    next_sr.q = resolve(SR_SET, SR_RESET, SR_OUT.q);
    next_csr.q = CSR_OUT.q;
    next_jk.q = JK_OUT.q;
    next_data.q = DATA_OUT.q;
    if (csr_trigger)
    begin
      next_csr.q = resolve(CSR_SET, CSR_RESET, CSR_OUT.q);
    end
    if (jk_trigger)
    begin
      if (JK_SET & JK_RESET)
      begin
        next_jk.q = ~JK_OUT.q;
      end
      else
      begin
        next_jk.q = resolve(JK_SET, JK_RESET, JK_OUT.q);
      end
    end
    if (data_trigger)
    begin
      next_data.q = DATA_IN;
    end
    if (SYS_RST)
    begin
      next_sr.q = SR_INITIAL;
      next_csr.q = CSR_INITIAL;
      next_jk.q = JK_INITIAL;
      next_data.q = DATA_INITIAL;
    end
    // complement registered alongside so both pins come from flops
    next_sr.q_n = ~next_sr.q;
    next_csr.q_n = ~next_csr.q;
    next_jk.q_n = ~next_jk.q;
    next_data.q_n = ~next_data.q;
  end

  // ==========================================================
  // output registers
  always_ff @(posedge REF_CLK)
  begin
    SR_OUT <= next_sr;
    CSR_OUT <= next_csr;
    JK_OUT <= next_jk;
    DATA_OUT <= next_data;
  end

endmodule

// *** verification/clock_source.sv ***
// partner that flips the primitive clock inputs
`timescale 1ns/10ps
module clock_source (
  input logic clk,
  input logic [2:0] go,
  output logic [2:0] lvl = 3'h0
);
  // falling edge keeps clear of the sampling edge
  always @(negedge clk)
    lvl <= lvl ^ go;
endmodule

// *** verification/flop_monitor.sv ***
// checker on the flop ports
`timescale 1ns/10ps
module flop_monitor (
  input logic REF_CLK,
  input logic SYS_RST,
  input logic SR_SET,
  input logic SR_RESET,
  input flop_pkg::flop_out_type SR_OUT,
  input logic CSR_SET,
  input logic CSR_RESET,
  input logic CSR_CLOCK,
  input flop_pkg::flop_out_type CSR_OUT,
  input logic JK_SET,
  input logic JK_RESET,
  input logic JK_CLOCK,
  input flop_pkg::flop_out_type JK_OUT,
  input logic DATA_IN,
  input logic DATA_CLOCK,
  input flop_pkg::flop_out_type DATA_OUT
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  chk_sr_set: assert property (SR_SET && !SR_RESET |=> SR_OUT.q) else $error("sr");
  chk_sr_clear: assert property (SR_RESET && !SR_SET |=> !SR_OUT.q) else $error("sr");
  chk_sr_hold: assert property (SR_SET == SR_RESET |=> $stable(SR_OUT)) else $error("sr");
  chk_out_pair: assert property (&{^SR_OUT, ^CSR_OUT, ^JK_OUT, ^DATA_OUT}) else $error("pair");
  chk_csr_quiet: assert property (!$rose(CSR_CLOCK) |=> $stable(CSR_OUT)) else $error("csr");
  chk_jk_quiet: assert property (!$rose(JK_CLOCK) |=> $stable(JK_OUT)) else $error("jk");
  chk_jk_toggle: assert property ($rose(JK_CLOCK) && JK_SET && JK_RESET |=> JK_OUT.q != $past(JK_OUT.q))
    else $error("jk");
  chk_data_follow: assert property ($rose(DATA_CLOCK) |=> DATA_OUT.q == $past(DATA_IN)) else $error("d");
  chk_data_quiet: assert property (!$rose(DATA_CLOCK) |=> $stable(DATA_OUT)) else $error("d");
  chk_csr_set: assert property ($rose(CSR_CLOCK) && CSR_SET && !CSR_RESET |=> CSR_OUT.q) else $error("csr");
  chk_csr_clear: assert property ($rose(CSR_CLOCK) && CSR_RESET && !CSR_SET |=> !CSR_OUT.q) else $error("csr");
endmodule
bind flip_flop_primitives flop_monitor flop_monitor_i (.*);

// *** verification/tb.sv ***
// flop bench
`timescale 1ns/10ps
module tb;
  logic REF_CLK = 1'h0, SYS_RST = 1'h1;
  logic SR_SET = 1'h0, SR_RESET = 1'h0, CSR_SET = 1'h0, CSR_RESET = 1'h0;
  logic JK_SET = 1'h0, JK_RESET = 1'h0, DATA_IN = 1'h0;
  logic [2:0] go = 3'h0;
  wire CSR_CLOCK, JK_CLOCK, DATA_CLOCK;
  flop_pkg::flop_out_type SR_OUT, CSR_OUT, JK_OUT, DATA_OUT;
  wire [7:0] seen = {SR_OUT, CSR_OUT, JK_OUT, DATA_OUT};
  int errors, cmp_count;
  flip_flop_primitives flip_flop_primitives_i (.*);
  clock_source clock_source_i (.clk(REF_CLK), .go(go), .lvl({CSR_CLOCK, JK_CLOCK, DATA_CLOCK}));
  initial forever #25 REF_CLK = ~REF_CLK;
  task give_verdict;
    $display("errors %0d of %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task step(logic [6:0] v, logic [2:0] m, logic [7:0] exp);
    @(negedge REF_CLK);
    {SR_SET, SR_RESET, CSR_SET, CSR_RESET, JK_SET, JK_RESET, DATA_IN} <= v;
    go <= m;
    @(negedge REF_CLK);
    go <= 3'h0;
    @(negedge REF_CLK);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR outputs expected %h seen %h", exp, seen);
    end
  endtask
  task sr_case;
    step(7'h00, 3'h0, 8'h55);
    step(7'h50, 3'h4, 8'ha5);
    step(7'h60, 3'h0, 8'ha5);
    step(7'h28, 3'h4, 8'h65);
  endtask
  task jk_case;
    step(7'h07, 3'h3, 8'h6a);
    step(7'h06, 3'h3, 8'h6a);
    step(7'h04, 3'h3, 8'h69);
  endtask
  initial
  begin
    repeat (6) @(negedge REF_CLK);
    SYS_RST <= 1'h0;
    sr_case();
    jk_case();
    give_verdict();
  end
  initial
  begin
    #4000;
    errors++;
    give_verdict();
  end
endmodule
